// ===== hdl/prx_stream_port.v
/*
 * Receive stream port: packs received TLP dwords into 64- or 128-bit words
 * with first/last/vacant markers, hit flags, function index and payload
 * byte enables, buffers them and drives them to the application.
 * Assumes the dword source and the application run on core_clk.
 */
// Overview of operation
// - Root Port hit flag bit 0 marks window 0, bit 1 window 1.
// - Flag bits 2, 3, 4: primary bus, secondary bus, secondary-subordinate range.
// - Flag bits 5, 6, 7: I/O, non-prefetchable, prefetchable memory window.
// - Hit flags appear with first word; only memory and I/O requests.
// - A 3-bit function index names the function the flags belong to.
// - Byte enables cover payload only; 8 or 16 bits by path width.
// - Enable bit i qualifies data byte lane i, bits 8i+7 to 8i.
// - Symbols packed little-endian, lowest address in lowest lane.
// - 64-bit path, 3-dword header, address ending 0x4: data0 in 63:32.
// - Word-valid drops within three cycles of accept going low.
// - Pending word held stable on the bus during backpressure.
// - Packets may follow back to back with no idle cycle.
// - 128-bit path, 3-dword header, address bit 2 set: data0 in 127:96.
// - Vacant-half low on last word whose data reaches upper 64 bits.
// - 128-bit last word may carry data in lower qword only.
// - First and last markers may coincide in one single-cycle packet.
`timescale 1ns/1ps
`include "prx_consts.vh"
module prx_stream_port #(
   parameter DATA_W = `PRX_DATA_W,
   parameter FIFO_DEPTH = `PRX_FIFO_DEPTH
) (
   input wire core_clk,
   input wire resetn,
   input wire [31:0] in_dword,
   input wire in_dword_valid,
   input wire in_dword_first,
   input wire in_dword_last,
   output reg in_dword_ready,
   input wire in_hit_win0,
   input wire in_hit_win1,
   input wire in_hit_prim_bus,
   input wire in_hit_sec_bus,
   input wire in_hit_bus_range,
   input wire in_hit_io_win,
   input wire in_hit_nonpref,
   input wire in_hit_pref,
   input wire [2:0] in_func_index,
   input wire rx_sink_accept,
   output reg [DATA_W-1:0] rx_payload_word,
   output reg [DATA_W/8-1:0] rx_payload_byte_enables,
   output reg rx_word_present,
   output reg rx_packet_first,
   output reg rx_packet_last,
   output reg rx_upper_half_vacant,
   output reg [7:0] rx_hit_window_flags,
   output reg [2:0] rx_function_index
);
   localparam NDW = DATA_W / 32;
   localparam BW = DATA_W / 8;
   localparam FW = DATA_W + BW + `PRX_SIDE_W;
   localparam AW = `PRX_FIFO_AW;

   // ----------------------------------------------------------------
   // Assembly state
   // ----------------------------------------------------------------
   reg [DATA_W-1:0] asm_data_reg;
   reg [BW-1:0] asm_be_reg;
   reg [3:0] asm_cnt_reg;
   reg asm_first_reg;
   reg [7:0] asm_hit_reg;
   reg [2:0] asm_func_reg;
   reg flush_reg;
   reg [2:0] idx_reg;
   reg hdr4_reg;
   reg par_reg;
   reg [3:0] fbe_reg;
   reg [3:0] lbe_reg;

   reg [DATA_W-1:0] asm_data_next;
   reg [BW-1:0] asm_be_next;
   reg [3:0] asm_cnt_next;
   reg asm_first_next;
   reg [7:0] asm_hit_next;
   reg [2:0] asm_func_next;
   reg flush_next;
   reg [2:0] idx_next;
   reg hdr4_next;
   reg par_next;
   reg [3:0] fbe_next;
   reg [3:0] lbe_next;

   reg emit;
   reg [DATA_W-1:0] e_data;
   reg [BW-1:0] e_be;
   reg [3:0] e_cnt;
   reg e_first;
   reg e_last;
   reg [7:0] e_hit;
   reg [2:0] e_func;
   reg [3:0] slot;
   reg [2:0] cur_idx;
   reg [2:0] hdr_len;
   reg is_pay;
   reg [3:0] be_d;
   reg [7:0] hit_enc;
   reg [4:0] tlp_type;
   integer k;

   wire take;
   wire f_wr_ready;
   wire f_rd_valid;
   wire [FW-1:0] f_rd_data;
   wire [AW:0] f_level;
   wire f_pop;
   wire e_vacant;
   wire [AW+1:0] lvl_next;

   assign take = in_dword_valid && in_dword_ready;

   // ----------------------------------------------------------------
   // Hit flag encoding
   // ----------------------------------------------------------------
   always @*
   begin
      hit_enc = 8'h00;
      tlp_type = in_dword[`PRX_TYPE_MSB:`PRX_TYPE_LSB];
      if (tlp_type == `PRX_TYPE_MEM || tlp_type == `PRX_TYPE_MEM_LK ||
          tlp_type == `PRX_TYPE_IO)
      begin
         hit_enc[`PRX_HIT_WIN0] = in_hit_win0;
         hit_enc[`PRX_HIT_WIN1] = in_hit_win1;
         hit_enc[`PRX_HIT_PRIM_BUS] = in_hit_prim_bus;
         hit_enc[`PRX_HIT_SEC_BUS] = in_hit_sec_bus;
         hit_enc[`PRX_HIT_BUS_RANGE] = in_hit_bus_range;
         hit_enc[`PRX_HIT_IO_WIN] = in_hit_io_win;
         hit_enc[`PRX_HIT_NONPREF] = in_hit_nonpref;
         hit_enc[`PRX_HIT_PREF] = in_hit_pref;
      end
   end

   // ----------------------------------------------------------------
   // Dword packer
   // ----------------------------------------------------------------
   always @*
   begin
      emit = 1'b0;
      e_data = asm_data_reg;
      e_be = asm_be_reg;
      e_cnt = asm_cnt_reg;
      e_first = asm_first_reg;
      e_last = 1'b0;
      e_hit = asm_hit_reg;
      e_func = asm_func_reg;
      asm_data_next = asm_data_reg;
      asm_be_next = asm_be_reg;
      asm_cnt_next = asm_cnt_reg;
      asm_first_next = asm_first_reg;
      asm_hit_next = asm_hit_reg;
      asm_func_next = asm_func_reg;
      flush_next = flush_reg;
      idx_next = idx_reg;
      hdr4_next = hdr4_reg;
      par_next = par_reg;
      fbe_next = fbe_reg;
      lbe_next = lbe_reg;
      slot = flush_reg ? 4'h0 : asm_cnt_reg;
      cur_idx = in_dword_first ? 3'h0 : idx_reg;
      hdr_len = hdr4_reg ? `PRX_HDR4_LEN : `PRX_HDR3_LEN;
      is_pay = !in_dword_first && (idx_reg >= hdr_len);
      be_d = 4'h0;
      if (flush_reg && (take || f_wr_ready))
      begin
         emit = 1'b1;
         e_last = 1'b1;
         flush_next = 1'b0;
         asm_data_next = {DATA_W{1'b0}};
         asm_be_next = {BW{1'b0}};
         asm_cnt_next = 4'h0;
         asm_first_next = 1'b0;
         asm_hit_next = 8'h00;
      end
      if (take)
      begin
         if (in_dword_first)
         begin
            hdr4_next = in_dword[`PRX_FMT4_BIT];
            asm_first_next = 1'b1;
            asm_hit_next = hit_enc;
            asm_func_next = in_func_index;
         end
         if (cur_idx == 3'h1)
         begin
            fbe_next = in_dword[`PRX_FBE_LSB +: 4];
            lbe_next = in_dword[`PRX_LBE_LSB +: 4];
         end
         if (!in_dword_first && idx_reg == hdr_len - 1'b1)
         begin
            par_next = in_dword[`PRX_ADDR2_BIT];
         end
         if (is_pay)
         begin
            // Payload dword sits in the half matching its address bit 2
            if (slot[0] != par_reg)
            begin
               slot = slot + 4'h1;
            end
            par_next = ~par_reg;
            be_d = (idx_reg == hdr_len) ? fbe_reg : (in_dword_last ? lbe_reg : 4'hF);
         end
         idx_next = in_dword_last ? 3'h0 : ((cur_idx == 3'h7) ? 3'h7 : cur_idx + 3'h1);
         if (slot == NDW[3:0])
         begin
            emit = 1'b1;
            slot = 4'h0;
            asm_data_next = {DATA_W{1'b0}};
            asm_be_next = {BW{1'b0}};
            asm_first_next = in_dword_first;
            asm_hit_next = in_dword_first ? hit_enc : 8'h00;
         end
         for (k = 0; k < NDW; k = k + 1)
         begin
            if (slot == k[3:0])
            begin
               asm_data_next[32*k +: 32] = in_dword;
               asm_be_next[4*k +: 4] = be_d;
            end
         end
         asm_cnt_next = slot + 4'h1;
         if (in_dword_last || asm_cnt_next == NDW[3:0])
         begin
            if (emit)
            begin
               flush_next = in_dword_last;
            end
            else
            begin
               emit = 1'b1;
               e_data = asm_data_next;
               e_be = asm_be_next;
               e_cnt = asm_cnt_next;
               e_first = asm_first_next;
               e_last = in_dword_last;
               e_hit = asm_hit_next;
               e_func = asm_func_next;
               asm_data_next = {DATA_W{1'b0}};
               asm_be_next = {BW{1'b0}};
               asm_cnt_next = 4'h0;
               asm_first_next = 1'b0;
               asm_hit_next = 8'h00;
            end
         end
      end
   end

   assign e_vacant = (NDW == 4) && e_last && (e_cnt <= 4'h2);

   // ----------------------------------------------------------------
   // Word buffer
   // ----------------------------------------------------------------
   prx_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH),
      .AW(AW)
   ) u_fifo (
      .core_clk(core_clk),
      .resetn(resetn),
      .wr_valid(emit),
      .wr_ready(f_wr_ready),
      .wr_data({e_hit, e_func, e_vacant, e_last, e_first, e_be, e_data}),
      .rd_valid(f_rd_valid),
      .rd_ready(f_pop),
      .rd_data(f_rd_data),
      .level(f_level)
   );

   assign f_pop = f_rd_valid && rx_sink_accept;
   assign lvl_next = {1'b0, f_level} + {{(AW+1){1'b0}}, emit} - {{(AW+1){1'b0}}, f_pop};

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         asm_data_reg <= {DATA_W{1'b0}};
         asm_be_reg <= {BW{1'b0}};
         asm_cnt_reg <= 4'h0;
         asm_first_reg <= 1'b0;
         asm_hit_reg <= 8'h00;
         asm_func_reg <= 3'h0;
         flush_reg <= 1'b0;
         idx_reg <= 3'h0;
         hdr4_reg <= 1'b0;
         par_reg <= 1'b0;
         fbe_reg <= 4'h0;
         lbe_reg <= 4'h0;
         in_dword_ready <= 1'b0;
      end
      else
      begin
         asm_data_reg <= asm_data_next;
         asm_be_reg <= asm_be_next;
         asm_cnt_reg <= asm_cnt_next;
         asm_first_reg <= asm_first_next;
         asm_hit_reg <= asm_hit_next;
         asm_func_reg <= asm_func_next;
         flush_reg <= flush_next;
         idx_reg <= idx_next;
         hdr4_reg <= hdr4_next;
         par_reg <= par_next;
         fbe_reg <= fbe_next;
         lbe_reg <= lbe_next;
         // Margin of three words covers the registered ready and a flush
         in_dword_ready <= (lvl_next + 3'h3 <= FIFO_DEPTH[AW+1:0]);
      end
   end

   // ----------------------------------------------------------------
   // Output stage
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_payload_word <= {DATA_W{1'b0}};
         rx_payload_byte_enables <= {BW{1'b0}};
         rx_word_present <= 1'b0;
         rx_packet_first <= 1'b0;
         rx_packet_last <= 1'b0;
         rx_upper_half_vacant <= 1'b0;
         rx_hit_window_flags <= 8'h00;
         rx_function_index <= 3'h0;
      end
      else
      begin
         rx_word_present <= f_pop;
         if (f_pop)
         begin
            rx_payload_word <= f_rd_data[DATA_W-1:0];
            rx_payload_byte_enables <= f_rd_data[DATA_W +: BW];
            rx_packet_first <= f_rd_data[DATA_W+BW];
            rx_packet_last <= f_rd_data[DATA_W+BW+1];
            rx_upper_half_vacant <= f_rd_data[DATA_W+BW+2];
            rx_function_index <= f_rd_data[DATA_W+BW+3 +: 3];
            rx_hit_window_flags <= f_rd_data[DATA_W+BW+6 +: 8];
         end
      end
   end
endmodule // prx_stream_port

// ===== hdl/prx_consts.vh
/*
 * Constants of the receive stream port: header field positions, hit flag
 * positions, encodings and buffer sizes.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef PRX_CONSTS_VH
`define PRX_CONSTS_VH

// ----------------------------------------------------------------------
// Header field positions within a received dword
// ----------------------------------------------------------------------
`define PRX_FMT4_BIT 29
`define PRX_TYPE_MSB 28
`define PRX_TYPE_LSB 24
`define PRX_FBE_LSB 0
`define PRX_LBE_LSB 4
`define PRX_ADDR2_BIT 2
`define PRX_HDR3_LEN 3'h3
`define PRX_HDR4_LEN 3'h4

// ----------------------------------------------------------------------
// Request type codes that qualify hit flags
// ----------------------------------------------------------------------
`define PRX_TYPE_MEM 5'h00
`define PRX_TYPE_MEM_LK 5'h01
`define PRX_TYPE_IO 5'h02

// ----------------------------------------------------------------------
// Root Port hit flag positions
// ----------------------------------------------------------------------
`define PRX_HIT_WIN0 0
`define PRX_HIT_WIN1 1
`define PRX_HIT_PRIM_BUS 2
`define PRX_HIT_SEC_BUS 3
`define PRX_HIT_BUS_RANGE 4
`define PRX_HIT_IO_WIN 5
`define PRX_HIT_NONPREF 6
`define PRX_HIT_PREF 7

// ----------------------------------------------------------------------
// Buffer and path sizes
// ----------------------------------------------------------------------
`define PRX_DATA_W 128
`define PRX_FIFO_DEPTH 8
`define PRX_FIFO_AW 3
`define PRX_SIDE_W 14

`endif

// ===== hdl/prx_fifo.v
/*
 * Synchronous FIFO with valid/ready on both sides and a fill level.
 * Assumes one clock shared by writer and reader; data read from the head.
 */
`timescale 1ns/1ps
`include "prx_consts.vh"
module prx_fifo #(
   parameter WIDTH = 160,
   parameter DEPTH = `PRX_FIFO_DEPTH,
   parameter AW = `PRX_FIFO_AW
) (
   input wire core_clk,
   input wire resetn,
   input wire wr_valid,
   output wire wr_ready,
   input wire [WIDTH-1:0] wr_data,
   output wire rd_valid,
   input wire rd_ready,
   output wire [WIDTH-1:0] rd_data,
   output wire [AW:0] level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wptr_reg;
   reg [AW-1:0] rptr_reg;
   reg [AW:0] cnt_reg;
   wire do_wr;
   wire do_rd;

   assign wr_ready = (cnt_reg != DEPTH[AW:0]);
   assign rd_valid = (cnt_reg != {(AW+1){1'b0}});
   assign do_wr = wr_valid && wr_ready;
   assign do_rd = rd_valid && rd_ready;
   assign rd_data = mem[rptr_reg];
   assign level = cnt_reg;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   always @(posedge core_clk)
   begin
      if (do_wr)
      begin
         mem[wptr_reg] <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // Pointers and count
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wptr_reg <= {AW{1'b0}};
         rptr_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
         begin
            wptr_reg <= (wptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_reg + 1'b1;
         end
         if (do_rd)
         begin
            rptr_reg <= (rptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_reg + 1'b1;
         end
         if (do_wr && !do_rd)
         begin
            cnt_reg <= cnt_reg + 1'b1;
         end
         else if (do_rd && !do_wr)
         begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule // prx_fifo

// ===== dv/prx_monitor.sv
/* Checker for the receive stream port outputs.
   Assumes binding to prx_stream_port on one clock with active-low reset. */
`timescale 1ns/1ps
module prx_monitor #(
   parameter DATA_W = 128
) (
   input wire core_clk,
   input wire resetn,
   input wire rx_sink_accept,
   input wire [DATA_W-1:0] rx_payload_word,
   input wire [DATA_W/8-1:0] rx_payload_byte_enables,
   input wire rx_word_present,
   input wire rx_packet_first,
   input wire rx_packet_last,
   input wire rx_upper_half_vacant,
   input wire [7:0] rx_hit_window_flags,
   input wire [2:0] rx_function_index
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   sequence s_accept_drop;
      $fell(rx_sink_accept);
   endsequence
   sequence s_idle;
      !rx_word_present;
   endsequence
   sequence s_last_word;
      rx_word_present && rx_packet_last;
   endsequence
   present_needs_accept_a: assert property (rx_word_present |-> $past(rx_sink_accept))
      else $error("word presented without accept");
   drop_within_three_a: assert property (s_accept_drop |-> ##[1:3] s_idle)
      else $error("word valid held after accept fell");
   data_hold_a: assert property (s_idle |-> $stable(rx_payload_word))
      else $error("data moved while no word presented");
   vacant_only_last_a: assert property (rx_word_present && rx_upper_half_vacant |-> rx_packet_last)
      else $error("vacant half outside last word");
   vacant_upper_empty_a: assert property (s_last_word ##0 rx_upper_half_vacant
      |-> rx_payload_byte_enables[15:8] == 8'h00)
      else $error("vacant half with upper enables");
   upper_busy_a: assert property (s_last_word ##0 (rx_payload_byte_enables[15:8] != 8'h00)
      |-> !rx_upper_half_vacant)
      else $error("vacant half with upper data");
   hits_first_only_a: assert property (rx_word_present && !rx_packet_first
      |-> rx_hit_window_flags == 8'h00)
      else $error("hit flags off the first word");
   header_lanes_a: assert property (rx_word_present && rx_packet_first
      |-> rx_payload_byte_enables[11:0] == 12'h000)
      else $error("enables on header lanes");
   back_to_back_c: cover property (s_last_word ##1 (rx_word_present && rx_packet_first));
endmodule // prx_monitor

bind prx_stream_port prx_monitor #(.DATA_W(DATA_W)) i_monitor (
   .core_clk(core_clk),
   .resetn(resetn),
   .rx_sink_accept(rx_sink_accept),
   .rx_payload_word(rx_payload_word),
   .rx_payload_byte_enables(rx_payload_byte_enables),
   .rx_word_present(rx_word_present),
   .rx_packet_first(rx_packet_first),
   .rx_packet_last(rx_packet_last),
   .rx_upper_half_vacant(rx_upper_half_vacant),
   .rx_hit_window_flags(rx_hit_window_flags),
   .rx_function_index(rx_function_index)
);

// ===== dv/prx_sink_model.sv
/* Application-side sink: records every presented word, drives accept.
   Assumes mode 0 accepts always, mode 1 stalls 40 cycles then alternates,
   mode 2 stalls 40 cycles then accepts always. */
`timescale 1ns/1ps
module prx_sink_model #(
   parameter W = 158
) (
   input wire core_clk,
   input wire resetn,
   input wire [1:0] mode,
   input wire [W-1:0] seen,
   input wire rx_word_present,
   output reg rx_sink_accept
);
   logic [W-1:0] got [$];
   int cyc = 0;
   initial rx_sink_accept = 1'b0;
   // Enables are stored but never needed to frame packets
   always @(posedge core_clk)
   begin
      if (rx_word_present)
      begin
         got.push_back(seen);
      end
   end
   always @(negedge core_clk)
   begin
      cyc = (mode == 2'h0) ? 0 : cyc + 1;
      rx_sink_accept <= resetn && (mode == 2'h0 || (cyc > 40 && (cyc[0] || mode == 2'h2)));
   end
endmodule // prx_sink_model

// ===== dv/prx_stream_port_tb.sv
/* Self-checking bench for the receive stream port, 128-bit path.
   Assumes the sink model consumes words; bench drives dwords at falling edges. */
`timescale 1ns/1ps
module prx_stream_port_tb;
   reg core_clk = 1'b0;
   reg resetn = 1'b0;
   reg [31:0] in_dword = 32'h0;
   reg in_dword_valid = 1'b0;
   reg in_dword_first = 1'b0;
   reg in_dword_last = 1'b0;
   reg [7:0] hv = 8'h00;
   reg [7:0] hits = 8'h00;
   reg [2:0] func = 3'h0;
   reg [1:0] mode = 2'h0;
   wire in_dword_ready, acc, present, first, last, vac;
   wire [127:0] word;
   wire [15:0] be;
   wire [7:0] flags;
   wire [2:0] fidx;
   wire [157:0] seen = {fidx, flags, first, last, vac, be, word};
   logic [157:0] expq [$];
   logic [157:0] mskq [$];
   logic [4:0] typs [5] = '{5'h00, 5'h01, 5'h02, 5'h0A, 5'h10};
   reg [127:0] ew;
   reg [15:0] eb;
   reg [3:0] em;
   reg [7:0] ef;
   reg [2:0] ef_f;
   reg [7:0] seq = 8'h00;
   reg fst;
   int p = 0;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   int refusals = 0;
   int b2b = 0;
   reg prev_last = 1'b0;
   always #50 core_clk = ~core_clk;
   // Counts a first word presented right after a last word
   always @(negedge core_clk)
   begin
      if (present && first && prev_last)
         b2b++;
      prev_last <= present && last;
   end
   prx_stream_port i_dut (.core_clk(core_clk), .resetn(resetn), .in_dword(in_dword),
      .in_dword_valid(in_dword_valid), .in_dword_first(in_dword_first),
      .in_dword_last(in_dword_last), .in_dword_ready(in_dword_ready),
      .in_hit_win0(hv[0]), .in_hit_win1(hv[1]), .in_hit_prim_bus(hv[2]),
      .in_hit_sec_bus(hv[3]), .in_hit_bus_range(hv[4]), .in_hit_io_win(hv[5]),
      .in_hit_nonpref(hv[6]), .in_hit_pref(hv[7]), .in_func_index(func),
      .rx_sink_accept(acc), .rx_payload_word(word), .rx_payload_byte_enables(be),
      .rx_word_present(present), .rx_packet_first(first), .rx_packet_last(last),
      .rx_upper_half_vacant(vac), .rx_hit_window_flags(flags), .rx_function_index(fidx));
   prx_sink_model i_sink (.core_clk(core_clk), .resetn(resetn), .mode(mode), .seen(seen),
      .rx_word_present(present), .rx_sink_accept(acc));
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         tally_and_finish;
      end
   end
   // ----------------------------------------------------------------
   // Checking and expected-word tasks
   // ----------------------------------------------------------------
   task check(input string what, input [157:0] got, input [157:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task emit(input bit lst);
      expq.push_back({ef_f, fst ? ef : 8'h00, fst, lst, lst && em[3:2] == 2'h0, eb, ew});
      mskq.push_back({fst ? 3'h7 : 3'h0, 27'h7FFFFFF, {32{em[3]}}, {32{em[2]}},
         {32{em[1]}}, {32{em[0]}}});
      fst = 1'b0;
      p = 0;
      ew = '0;
      eb = '0;
      em = '0;
   endtask
   task place(input [31:0] d, input [3:0] b);
      ew[32*p +: 32] = d;
      eb[4*p +: 4] = b;
      em[p] = 1'b1;
      p++;
   endtask
   task push(input [31:0] d, input bit f, input bit l, input [7:0] h);
      in_dword = d;
      in_dword_first = f;
      in_dword_last = l;
      hv = h;
      in_dword_valid = 1'b1;
      while (!in_dword_ready)
      begin
         refusals++;
         @(negedge core_clk);
      end
      @(negedge core_clk);
   endtask
   task send(input [4:0] typ, input bit h4, input bit a2, input int nd);
      int j;
      int hl;
      int k;
      reg [31:0] d;
      hl = h4 ? 4 : 3;
      ef = (typ <= 5'h02) ? hits : 8'h00;
      ef_f = func;
      fst = 1'b1;
      seq++;
      for (j = 0; j < hl + nd; j++)
      begin
         k = j - hl;
         d = (j == 0) ? {2'h0, h4, typ, 24'h0} : (j == 1) ? 32'h000000A3 :
            (j < hl) ? {29'h0, a2, 2'h0} : {8'hD0, seq, 8'h00, j[7:0]};
         push(d, j == 0, j == hl + nd - 1, (j == 0) ? hits : ~hits);
         if (p == 4) emit(1'b0);
         if (j >= hl && p[0] != (a2 ^ k[0])) p++;
         if (p == 4) emit(1'b0);
         place(d, (j < hl) ? 4'h0 : (k == 0) ? 4'h3 : (k == nd - 1) ? 4'hA : 4'hF);
      end
      emit(1'b1);
   endtask
   task drain(input string name);
      int k;
      in_dword_valid = 1'b0;
      for (k = 0; k < 2000 && i_sink.got.size() < expq.size(); k++) @(negedge core_clk);
      check({name, " count"}, 158'(i_sink.got.size()), 158'(expq.size()));
      for (k = 0; k < expq.size() && k < i_sink.got.size(); k++)
         check(name, i_sink.got[k] & mskq[k], expq[k] & mskq[k]);
      i_sink.got.delete();
      expq.delete();
      mskq.delete();
      $display("test %s done", name);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_align;
      hits = 8'h01;
      func = 3'h1;
      send(5'h00, 1'b0, 1'b1, 1);
      send(5'h00, 1'b0, 1'b0, 3);
      send(5'h00, 1'b1, 1'b0, 2);
      send(5'h00, 1'b1, 1'b1, 2);
      send(5'h02, 1'b1, 1'b1, 5);
      drain("align");
   endtask
   task t_hits;
      int i;
      int t;
      for (i = 0; i < 8; i++)
         for (t = 0; t < 5; t++)
         begin
            hits = 8'h01 << i;
            func = i[2:0];
            send(typs[t], t[0], 1'b1, 1);
         end
      drain("hits");
   endtask
   task t_stall;
      int i;
      mode = 2'h1;
      refusals = 0;
      for (i = 0; i < 12; i++) send(5'h00, 1'b1, i[0], 4);
      drain("stall");
      check("refused", 158'(refusals != 0), 158'h1);
      mode = 2'h0;
   endtask
   task t_burst;
      int i;
      repeat (2) @(negedge core_clk);
      mode = 2'h2;
      b2b = 0;
      for (i = 0; i < 6; i++) send(5'h00, 1'b0, 1'b1, 1);
      drain("burst");
      check("back to back", 158'(b2b != 0), 158'h1);
      mode = 2'h0;
   endtask
   task tally_and_finish;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(negedge core_clk);
      resetn = 1'b1;
      repeat (2) @(negedge core_clk);
      t_align;
      t_hits;
      t_stall;
      t_burst;
      tally_and_finish;
   end
endmodule // prx_stream_port_tb
